// ==== hw/ptse_top.sv ====
// Overview of operation
// [RULE1] sync source 000 external input, 010 generator output 16, 011 output 17
// [RULE2] software never programs source codes 001 or 100 through 111
// [RULE3] postscale field value plus one compare matches per special event trigger
// [RULE4] postscale 0000 triggers on every compare match
// [RULE5] postscale 0001 triggers on every second compare match
// [RULE6] software changes source and postscale only while time base disabled
// [RULE7] with external sync, period set slightly above external sync period
// [RULE8] event counter cleared when disabled, counts matches, wraps on trigger
`timescale 1ns/1ps
module ptse_top
  import ptse_pkg::*;
(
  input wire logic ref_clk_i, // 50 MHz clock
  input wire logic sys_rst_i, // sync reset, active high
  input wire logic [ptse_pkg::PTSE_ADDR_W-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read strobe
  input wire logic avs_write_i, // write strobe
  input wire logic [ptse_pkg::PTSE_DATA_W-1:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte enables
  output logic [ptse_pkg::PTSE_DATA_W-1:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic external_sync_input_i, // pin-routed sync input
  input wire logic trigger_gen_output_16_i, // trigger generator output 16
  input wire logic trigger_gen_output_17_i, // trigger generator output 17
  input wire logic compare_match_i, // compare-match event pulse
  output logic time_base_enable_o, // time base enable
  output logic sync_o, // selected sync, registered
  output logic special_event_trigger_o // special event trigger pulse
);
  import ptse_pkg::*;

  ptse_cfg_if cfg();

  logic [15:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic sync_reg;
  logic trig;
  logic [3:0] cnt;
  logic sel_sync;
  logic bad;

  // one wait cycle per access, answer on the second edge
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= PTSE_CTRL_RST;
    end else if (avs_write_i && ack_reg && avs_address_i == PTSE_OFF_CTRL) begin
      if (avs_byteenable_i[0]) begin
        ctrl_reg[7:0] <= avs_writedata_i[7:0] & PTSE_CTRL_MASK[7:0];
      end
      if (avs_byteenable_i[1]) begin
        ctrl_reg[15:8] <= avs_writedata_i[15:8] & PTSE_CTRL_MASK[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= '0;
    end else if (avs_read_i && !ack_reg) begin
      if (avs_address_i == PTSE_OFF_CTRL) begin
        rdata_reg <= {16'h0000, ctrl_reg};
      end else if (avs_address_i == PTSE_OFF_STAT) begin
        rdata_reg <= '0;
        rdata_reg[PTSE_STAT_CNT_LSB +: 4] <= cfg.ps_count;
        rdata_reg[PTSE_STAT_SYNC_BIT] <= cfg.sync_level;
        rdata_reg[PTSE_STAT_BAD_BIT] <= cfg.src_reserved;
      end else begin
        rdata_reg <= PTSE_UNMAPPED_RD;
      end
    end
  end

  assign avs_readdata_o = rdata_reg;

  assign cfg.time_base_enable = ctrl_reg[PTSE_EN_BIT];
  assign cfg.sync_source_select = ctrl_reg[PTSE_SRC_LSB +: PTSE_SRC_W];
  assign cfg.event_trigger_postscale = ctrl_reg[PTSE_PS_LSB +: PTSE_PS_W];

  // reserved codes give no sync and are flagged in status
  always_comb begin
    sel_sync = 1'b0;
    bad = 1'b0;
    case (cfg.sync_source_select)
      PTSE_SRC_EXT: sel_sync = external_sync_input_i; // [RULE1]
      PTSE_SRC_TG16: sel_sync = trigger_gen_output_16_i; // [RULE1]
      PTSE_SRC_TG17: sel_sync = trigger_gen_output_17_i; // [RULE1]
      default: bad = 1'b1; // [RULE2]
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !cfg.time_base_enable) begin
      sync_reg <= 1'b0;
    end else begin
      sync_reg <= sel_sync; // [RULE1]
    end
  end

  assign cfg.sync_level = sync_reg;
  assign cfg.src_reserved = bad;
  assign cfg.ps_count = cnt;

  ptse_postscale #(
    .PS_W(PTSE_PS_W)
  ) u_ps (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(cfg.time_base_enable),
    .ratio_i(cfg.event_trigger_postscale),
    .match_i(compare_match_i),
    .trig_o(trig),
    .count_o(cnt)
  );

  assign time_base_enable_o = cfg.time_base_enable;
  assign sync_o = sync_reg;
  assign special_event_trigger_o = trig;
endmodule

// ==== hw/ptse_pkg.sv ====
package ptse_pkg;
  localparam int PTSE_ADDR_W = 4;
  localparam int PTSE_DATA_W = 32;
  // register byte offsets
  localparam logic [3:0] PTSE_OFF_CTRL = 4'h0;
  localparam logic [3:0] PTSE_OFF_STAT = 4'h4;
  // control register fields (16-bit pwm_time_base_control image)
  localparam int PTSE_EN_BIT = 15;
  localparam int PTSE_SRC_LSB = 4;
  localparam int PTSE_SRC_W = 3;
  localparam int PTSE_PS_LSB = 0;
  localparam int PTSE_PS_W = 4;
  localparam logic [15:0] PTSE_CTRL_RST = 16'h0000;
  localparam logic [15:0] PTSE_CTRL_MASK = 16'h807F;
  // status register fields
  localparam int PTSE_STAT_CNT_LSB = 0;
  localparam int PTSE_STAT_SYNC_BIT = 8;
  localparam int PTSE_STAT_BAD_BIT = 9;
  // sync source codes
  localparam logic [2:0] PTSE_SRC_EXT = 3'h0;
  localparam logic [2:0] PTSE_SRC_TG16 = 3'h2;
  localparam logic [2:0] PTSE_SRC_TG17 = 3'h3;
  localparam logic [3:0] PTSE_PS_RST = 4'h0;
  localparam logic [31:0] PTSE_UNMAPPED_RD = 32'h0000_0000;
endpackage

// ==== hw/ptse_cfg_if.sv ====
`timescale 1ns/1ps
interface ptse_cfg_if;
  logic time_base_enable;
  logic [2:0] sync_source_select;
  logic [3:0] event_trigger_postscale;
  logic [3:0] ps_count;
  logic sync_level;
  logic src_reserved;
  modport regs (output time_base_enable, output sync_source_select, output event_trigger_postscale,
                input ps_count, input sync_level, input src_reserved);
  modport core (input time_base_enable, input sync_source_select, input event_trigger_postscale,
                output ps_count, output sync_level, output src_reserved);
endinterface

// ==== hw/ptse_postscale.sv ====
`timescale 1ns/1ps
module ptse_postscale
  import ptse_pkg::*;
#(
  parameter int PS_W = 4
) (
  input wire logic ref_clk_i, // clock
  input wire logic sys_rst_i, // sync reset, high
  input wire logic enable_i, // time base enable
  input wire logic [PS_W-1:0] ratio_i, // divide ratio minus one
  input wire logic match_i, // compare-match event pulse
  output logic trig_o, // special event trigger pulse
  output logic [PS_W-1:0] count_o // event counter
);
  logic [PS_W-1:0] cnt_reg;
  logic trig_reg;
  logic hit;

  assign hit = (cnt_reg >= ratio_i);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !enable_i) begin
      cnt_reg <= '0; // [RULE8]
    end else if (match_i) begin
      if (hit) begin
        cnt_reg <= '0; // [RULE8] [RULE3]
      end else begin
        cnt_reg <= cnt_reg + 1'b1; // [RULE8]
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !enable_i) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= match_i && hit; // [RULE3] [RULE4] [RULE5]
    end
  end

  assign trig_o = trig_reg;
  assign count_o = cnt_reg;
endmodule

// ==== dv/ptse_chk_assertions.sv ====
`timescale 1ns/1ps
module ptse_chk(
  input wire logic ref_clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic [3:0] avs_address_i, // address
  input wire logic avs_write_i, // write
  input wire logic [31:0] avs_writedata_i, // data
  input wire logic avs_waitrequest_o, // stall
  input wire logic external_sync_input_i, // source 0
  input wire logic trigger_gen_output_16_i, // source 2
  input wire logic trigger_gen_output_17_i, // source 3
  input wire logic compare_match_i, // match
  input wire logic time_base_enable_o, // enable
  input wire logic sync_o, // sync
  input wire logic special_event_trigger_o // trigger
);
  logic [15:0] ctl_reg;
  logic [3:0] cnt_reg;
  logic s;
  // shadow of the control register as written over the bus
  always_ff @(posedge ref_clk_i)
    if (sys_rst_i) ctl_reg <= 16'h0000;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) ctl_reg <= avs_writedata_i[15:0];
  always_ff @(posedge ref_clk_i)
    if (sys_rst_i || !time_base_enable_o) cnt_reg <= 4'h0;
    else if (compare_match_i) cnt_reg <= (cnt_reg == ctl_reg[3:0]) ? 4'h0 : cnt_reg + 4'h1;
  assign s = ctl_reg[6:4] == 3'h0 ? external_sync_input_i : ctl_reg[6:4] == 3'h2 ? trigger_gen_output_16_i :
    ctl_reg[6:4] == 3'h3 ? trigger_gen_output_17_i : 1'b0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_sync_follow: assert property (sync_o == $past(time_base_enable_o && s))
    else $error("sync mismatch");
  a_trig_count: assert property (time_base_enable_o && compare_match_i |=>
    special_event_trigger_o == ($past(cnt_reg) == $past(ctl_reg[3:0]))) else $error("trigger count");
  a_ratio_one: assert property (time_base_enable_o && compare_match_i && ctl_reg[3:0] == 4'h0 |=>
    special_event_trigger_o) else $error("ratio one");
  a_trig_cause: assert property (special_event_trigger_o |-> $past(compare_match_i && time_base_enable_o))
    else $error("stray trigger");
  a_off_quiet: assert property (!time_base_enable_o |=> !special_event_trigger_o)
    else $error("trigger while off");
endmodule
bind ptse_top ptse_chk ptse_chk_i(.*);

// ==== dv/ptse_far.sv ====
`timescale 1ns/1ps
module ptse_far(
  input wire logic ref_clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic [3:0] gap_i, // idle cycles between matches
  input wire logic run_i, // matches allowed while high
  output logic match_o, // match pulse
  output logic [2:0] src_o // sync sources
);
  logic [3:0] cnt_reg;
  always_ff @(posedge ref_clk_i) begin
    cnt_reg <= (sys_rst_i || cnt_reg >= gap_i) ? 4'h0 : cnt_reg + 4'h1;
    match_o <= !sys_rst_i && run_i && cnt_reg == gap_i;
    src_o <= sys_rst_i ? 3'h0 : src_o + 3'h3;
  end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import ptse_pkg::*;
  logic ref_clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o, compare_match_i;
  logic external_sync_input_i, trigger_gen_output_16_i, trigger_gen_output_17_i;
  logic time_base_enable_o, sync_o, special_event_trigger_o;
  logic [3:0] avs_address_i = 4'h0, gap = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic [2:0] src;
  logic go = 1'b0;
  int n_mismatch = 0, n_checks = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  assign {trigger_gen_output_17_i, trigger_gen_output_16_i, external_sync_input_i} = src;
  ptse_far ptse_far_i(.ref_clk_i, .sys_rst_i, .gap_i(gap), .run_i(go), .match_o(compare_match_i), .src_o(src));
  ptse_top ptse_top_i(.*, .avs_byteenable_i(4'hF));
  task automatic chk(input string s, input logic [31:0] e, v);
    n_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // request held from a rising edge until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      n_mismatch++;
      $display("BAD bus waitrequest exp 0 got %b", avs_waitrequest_o);
      close_out;
    end else begin
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask
  // count matches and the triggers they cause while the time base runs
  task automatic run(input logic [2:0] c, input logic [3:0] r, g);
    int m;
    int t;
    m = 0;
    t = 0;
    gap <= g;
    bus(1, PTSE_OFF_CTRL, {25'h0, c, r});
    bus(1, PTSE_OFF_CTRL, {16'h0, 1'b1, 8'h0, c, r});
    go <= 1'b1;
    @(negedge ref_clk_i);
    chk("enable", 32'h1, 32'(time_base_enable_o));
    repeat (100) begin
      @(negedge ref_clk_i);
      m += compare_match_i;
      t += special_event_trigger_o;
    end
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (20) begin
      @(negedge ref_clk_i);
      m += compare_match_i;
      t += special_event_trigger_o;
    end
    chk("triggers", 32'(m / (r + 1)), 32'(t));
    bus(0, PTSE_OFF_STAT, 0);
    chk("count", 32'(m % (r + 1)), rd & 32'hF);
    chk("reserved flag", 32'h0, (rd >> PTSE_STAT_BAD_BIT) & 32'h1);
    bus(1, PTSE_OFF_CTRL, 0);
    bus(0, PTSE_OFF_STAT, 0);
    chk("count off", 32'h0, rd & 32'hF);
    $display("test src %0d ratio %0d done", c, r);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    bus(0, PTSE_OFF_CTRL, 0);
    chk("ctrl reset", 32'(PTSE_CTRL_RST), rd);
    bus(1, PTSE_OFF_CTRL, 32'hFFFF_7FBF);
    bus(0, PTSE_OFF_CTRL, 0);
    chk("ctrl bits", 32'h0000_003F, rd);
    bus(0, 4'h8, 0);
    chk("unmapped", PTSE_UNMAPPED_RD, rd);
    $display("test registers done");
    run(PTSE_SRC_EXT, 4'h0, 4'h0);
    run(PTSE_SRC_TG16, 4'h1, 4'h2);
    run(PTSE_SRC_TG17, 4'hF, 4'h1);
    close_out;
  end
endmodule
